// >>> inc/ddrcp_pkg.sv
package ddrcp_pkg;
  // command codes {select_n, row_n, col_n, we_n}
  localparam logic [3:0] CMD_MRS   = 4'h0;
  localparam logic [3:0] CMD_REF   = 4'h1;
  localparam logic [3:0] CMD_PRE   = 4'h2;
  localparam logic [3:0] CMD_ACT   = 4'h3;
  localparam logic [3:0] CMD_WR    = 4'h4;
  localparam logic [3:0] CMD_RD    = 4'h5;
  localparam logic [3:0] CMD_ZQ    = 4'h6;
  localparam logic [3:0] CMD_NOP   = 4'h7;
  // address field positions
  localparam int AP_BIT      = 10;
  localparam int BC_BIT      = 12;
  localparam int TDQS_BIT    = 11;
  localparam int RTT_NOM_B0  = 2;
  localparam int RTT_NOM_B1  = 6;
  localparam int RTT_NOM_B2  = 9;
  localparam int RTT_WR_LO   = 9;
  localparam int RTT_WR_HI   = 10;
  localparam int COL_W       = 10;
  // mode register selectors on the bank inputs
  localparam logic [2:0] MR_SEL_1 = 3'h1;
  localparam logic [2:0] MR_SEL_2 = 3'h2;
  localparam logic [15:0] MR_RESET = 16'h0000;
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int TRFC_NS       = 160;
  localparam int TRFC_CYC      = (TRFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TREFI_HOT_NS  = 3900;
  localparam int TREFI_HOT_CYC = TREFI_HOT_NS / CLK_PERIOD_NS;
  // power states, one-hot
  typedef enum logic [3:0] {
    PS_RUN  = 4'b0001,
    PS_PPD  = 4'b0010,
    PS_APD  = 4'b0100,
    PS_SREF = 4'b1000
  } ddrcp_pwr_t;
endpackage

// >>> verilog/ddrcp_wbuf.sv
`timescale 1ns/10ps
`default_nettype none
// two-entry buffer, holds two words while the sink stalls, then drops ready and takes no more
module ddrcp_wbuf #(
  parameter int W = 16
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);
  logic [W-1:0] mem_reg [2];
  logic         wp_reg;
  logic         rp_reg;
  logic [1:0]   cnt_reg;
  wire          push = in_valid_i && in_ready_o;
  wire          pop  = out_valid_o && out_ready_i;

  ////////////////////////////////////////////////////////////////////////////
  // flags from the fill count
  assign in_ready_o  = (cnt_reg != 2'h2);
  assign out_valid_o = (cnt_reg != 2'h0);
  assign out_data_o  = mem_reg[rp_reg];

  // pointers and fill count
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
      cnt_reg <= 2'h0;
    end else begin
      if (push) wp_reg <= ~wp_reg;
      if (pop) rp_reg <= ~rp_reg;
      cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
    end
  end

  // data words need no reset
  always_ff @(posedge core_clk_i) begin
    if (push) mem_reg[wp_reg] <= in_data_i;
  end

  property p_no_overflow;
    @(posedge core_clk_i) disable iff (rst_i) cnt_reg <= 2'h2;
  endproperty
  a_no_overflow : assert property (p_no_overflow) else $error("buffer over two words");
endmodule // ddrcp_wbuf
`default_nettype wire

// >>> verilog/ddrcp_core.sv
`timescale 1ns/10ps
`default_nettype none
module ddrcp_core
  import ddrcp_pkg::*;
#(
  parameter int ADDR_W = 15,
  parameter int BANK_W = 3,
  parameter int DQ_W   = 16,
  parameter int DM_W   = 2
) (
  input  wire logic              core_clk_i,
  input  wire logic              rst_i,
  input  wire logic              cke_i,
  input  wire logic              cs_n_i,
  input  wire logic              ras_n_i,
  input  wire logic              cas_n_i,
  input  wire logic              we_n_i,
  input  wire logic [BANK_W-1:0] ba_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              odt_i,
  input  wire logic              wr_beat_i,
  input  wire logic [DQ_W-1:0]   dq_i,
  input  wire logic [DM_W-1:0]   dm_i,
  output logic                   wbeat_ready_o,
  output logic                   wdata_valid_o,
  output logic [DQ_W-1:0]        wdata_o,
  input  wire logic              wdata_ready_i,
  input  wire logic              rd_valid_i,
  input  wire logic [DQ_W-1:0]   rd_data_i,
  output logic [DQ_W-1:0]        dq_o,
  output logic                   dq_oe_n_o,
  output logic                   dqs_t_o,
  output logic                   dqs_c_o,
  output logic                   dqs_oe_n_o,
  output logic                   cmd_act_o,
  output logic                   cmd_rd_o,
  output logic                   cmd_wr_o,
  output logic                   cmd_pre_o,
  output logic                   cmd_ref_o,
  output logic                   cmd_mrs_o,
  output logic [BANK_W-1:0]      cmd_bank_o,
  output logic [ADDR_W-1:0]      cmd_addr_o,
  output logic                   cmd_ap_o,
  output logic                   cmd_pre_all_o,
  output logic                   cmd_full_burst_o,
  output logic [7:0]             bank_open_o,
  output logic [3:0]             pwr_state_o,
  output logic                   odt_on_o,
  output logic                   tdqs_en_o,
  output logic                   trfc_err_o
);
  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  if (BANK_W != 3) begin : g_bad_bank
    $error("bank width must be 3 for eight banks");
  end
  if (ADDR_W <= BC_BIT || DQ_W % DM_W != 0) begin : g_bad_width
    $error("address must hold bit twelve and data must split into mask lanes");
  end

  localparam int LANE_W = DQ_W / DM_W;

  function automatic logic [7:0] bank_bit(input logic [BANK_W-1:0] b);
    bank_bit = 8'h01 << b;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state
  ddrcp_pwr_t   pwr_reg;
  ddrcp_pwr_t   pwr_next;
  logic [7:0]   open_reg;
  logic [15:0]  mr1_reg;
  logic [15:0]  mr2_reg;
  logic [2:0]   cke_sync_reg;
  logic [3:0]   trfc_cnt_reg;
  logic         dqs_reg;

  ////////////////////////////////////////////////////////////////////////////
  // command decode, inputs taken at the rising edge
  wire [3:0] cmd_code = {cs_n_i, ras_n_i, cas_n_i, we_n_i};
  wire       run      = (pwr_reg == PS_RUN) && cke_i;
  wire       sel      = run && !cs_n_i;
  wire       is_act   = sel && (cmd_code == CMD_ACT);
  wire       is_rd    = sel && (cmd_code == CMD_RD);
  wire       is_wr    = sel && (cmd_code == CMD_WR);
  wire       is_pre   = sel && (cmd_code == CMD_PRE);
  wire       is_ref   = sel && (cmd_code == CMD_REF);
  wire       is_mrs   = sel && (cmd_code == CMD_MRS);
  wire       ap       = addr_i[AP_BIT];
  wire [7:0] bsel     = bank_bit(ba_i);
  wire       any_open = (open_reg != 8'h00);

  // bank state: activate opens, precharge closes one or all
  wire [7:0] open_set = is_act ? bsel : 8'h00;
  wire [7:0] open_clr = is_pre ? (ap ? 8'hff : bsel) :
                        ((is_rd || is_wr) && ap) ? bsel : 8'h00;
  wire [7:0] open_nxt = (open_reg & ~open_clr) | open_set;

  ////////////////////////////////////////////////////////////////////////////
  // power state
  wire cke_exit_sr = cke_sync_reg[1] && cke_sync_reg[2];
  // stale high stages from before entry would end self-refresh at once
  wire sr_enter    = (pwr_reg == PS_RUN) && (pwr_next == PS_SREF);

  always_comb begin
    pwr_next = pwr_reg;
    case (pwr_reg)
      PS_RUN: begin
        if (!cke_i) begin
          if (!cs_n_i && cmd_code == CMD_REF && !any_open) pwr_next = PS_SREF;
          else if (any_open) pwr_next = PS_APD;
          else pwr_next = PS_PPD;
        end
      end
      PS_PPD, PS_APD: begin
        if (cke_i) pwr_next = PS_RUN;
      end
      PS_SREF: begin
        if (cke_exit_sr) pwr_next = PS_RUN;
      end
      default: pwr_next = PS_RUN;
    endcase
  end

  // power state, banks, synchroniser for the self-refresh exit
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pwr_reg      <= PS_RUN;
      open_reg     <= 8'h00;
      cke_sync_reg <= 3'h0;
    end else begin
      pwr_reg      <= pwr_next;
      open_reg     <= open_nxt;
      cke_sync_reg <= sr_enter ? 3'h0 : {cke_sync_reg[1:0], cke_i};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode registers one and two captured on a mode set
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      mr1_reg <= MR_RESET;
      mr2_reg <= MR_RESET;
    end else if (is_mrs) begin
      if (ba_i == MR_SEL_1) mr1_reg <= 16'(addr_i);
      if (ba_i == MR_SEL_2) mr2_reg <= 16'(addr_i);
    end
  end

  // termination gating
  wire rtt_nom_on = mr1_reg[RTT_NOM_B0] | mr1_reg[RTT_NOM_B1] | mr1_reg[RTT_NOM_B2];
  wire rtt_wr_on  = mr2_reg[RTT_WR_LO] | mr2_reg[RTT_WR_HI];
  wire odt_live   = (pwr_reg != PS_SREF);

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      odt_on_o  <= 1'b0;
      tdqs_en_o <= 1'b0;
    end else begin
      odt_on_o  <= odt_i && odt_live && (rtt_nom_on || rtt_wr_on);
      tdqs_en_o <= mr1_reg[TDQS_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered command outputs
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_act_o        <= 1'b0;
      cmd_rd_o         <= 1'b0;
      cmd_wr_o         <= 1'b0;
      cmd_pre_o        <= 1'b0;
      cmd_ref_o        <= 1'b0;
      cmd_mrs_o        <= 1'b0;
      cmd_bank_o       <= '0;
      cmd_addr_o       <= '0;
      cmd_ap_o         <= 1'b0;
      cmd_pre_all_o    <= 1'b0;
      cmd_full_burst_o <= 1'b1;
    end else begin
      cmd_act_o     <= is_act;
      cmd_rd_o      <= is_rd;
      cmd_wr_o      <= is_wr;
      cmd_pre_o     <= is_pre;
      cmd_ref_o     <= is_ref;
      cmd_mrs_o     <= is_mrs;
      if (sel) begin
        cmd_bank_o  <= ba_i;
        cmd_addr_o  <= (is_rd || is_wr) ? ADDR_W'(addr_i[COL_W-1:0]) : addr_i;
        cmd_ap_o    <= (is_rd || is_wr) && ap;
        cmd_pre_all_o <= is_pre && ap;
        cmd_full_burst_o <= !(is_rd || is_wr) || addr_i[BC_BIT];
      end
    end
  end

  assign bank_open_o = open_reg;
  assign pwr_state_o = pwr_reg;

  ////////////////////////////////////////////////////////////////////////////
  // refresh spacing watch, flags early refresh or activate
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      trfc_cnt_reg <= 4'h0;
      trfc_err_o   <= 1'b0;
    end else begin
      if (is_ref) trfc_cnt_reg <= 4'(TRFC_CYC - 1);
      else if (trfc_cnt_reg != 4'h0) trfc_cnt_reg <= trfc_cnt_reg - 4'h1;
      trfc_err_o <= (is_ref || is_act) && (trfc_cnt_reg != 4'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write path: masked lanes replaced, fully masked beats dropped
  logic [DQ_W-1:0] beat_keep;
  always_comb begin
    beat_keep = '0;
    for (int i = 0; i < DM_W; i++) begin
      beat_keep[i*LANE_W +: LANE_W] = dm_i[i] ? '0 : dq_i[i*LANE_W +: LANE_W];
    end
  end
  wire beat_take = wr_beat_i && (pwr_reg == PS_RUN) && (dm_i != '1);

  ddrcp_wbuf #(.W(DQ_W)) u_wbuf (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (beat_take),
    .in_data_i   (beat_keep),
    .in_ready_o  (wbeat_ready_o),
    .out_valid_o (wdata_valid_o),
    .out_data_o  (wdata_o),
    .out_ready_i (wdata_ready_i)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read path: strobe toggles on the same edge as the data
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dq_o       <= '0;
      dq_oe_n_o  <= 1'b1;
      dqs_reg    <= 1'b0;
      dqs_oe_n_o <= 1'b1;
    end else begin
      dq_oe_n_o  <= !rd_valid_i;
      dqs_oe_n_o <= !rd_valid_i;
      if (rd_valid_i) begin
        dq_o    <= rd_data_i;
        dqs_reg <= ~dqs_reg;
      end
    end
  end
  assign dqs_t_o = dqs_reg;
  assign dqs_c_o = ~dqs_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence s_ref_cmd;
    !cs_n_i && cmd_code == CMD_REF && run;
  endsequence
  sequence s_early;
    ##[1:3] (!cs_n_i && (cmd_code == CMD_REF || cmd_code == CMD_ACT) && run);
  endsequence

  property p_desel;
    cs_n_i |=> !(cmd_act_o || cmd_rd_o || cmd_wr_o || cmd_pre_o || cmd_ref_o || cmd_mrs_o);
  endproperty
  a_desel : assert property (p_desel) else $error("command taken while deselected");

  property p_act_open;
    is_act |=> cmd_act_o && open_reg[$past(ba_i)];
  endproperty
  a_act_open : assert property (p_act_open) else $error("activate left bank closed");

  property p_pre_all;
    is_pre && ap |=> open_reg == 8'h00 && cmd_pre_all_o;
  endproperty
  a_pre_all : assert property (p_pre_all) else $error("precharge all left a bank open");

  property p_ap;
    (is_rd || is_wr) && ap |=> cmd_ap_o && !open_reg[$past(ba_i)];
  endproperty
  a_ap : assert property (p_ap) else $error("auto precharge not applied");

  property p_chop;
    (is_rd || is_wr) |=> cmd_full_burst_o == $past(addr_i[BC_BIT]);
  endproperty
  a_chop : assert property (p_chop) else $error("burst chop mismatch");

  property p_pd_entry;
    pwr_reg == PS_RUN && !cke_i && !(!cs_n_i && cmd_code == CMD_REF)
      |=> pwr_reg == ($past(any_open) ? PS_APD : PS_PPD);
  endproperty
  a_pd_entry : assert property (p_pd_entry) else $error("wrong power-down kind");

  property p_sr_exit;
    pwr_reg == PS_SREF && cke_i [*3] |=> ##[0:1] pwr_reg == PS_RUN;
  endproperty
  a_sr_exit : assert property (p_sr_exit) else $error("self-refresh exit missed");

  property p_sr_odt;
    pwr_reg == PS_SREF |=> !odt_on_o;
  endproperty
  a_sr_odt : assert property (p_sr_odt) else $error("termination on in self-refresh");

  property p_trfc;
    s_ref_cmd ##0 s_early |=> trfc_err_o;
  endproperty
  a_trfc : assert property (p_trfc) else $error("early refresh not flagged");

  property p_mask;
    wr_beat_i && dm_i == '1 && !(wdata_valid_o && wdata_ready_i)
      |=> wdata_valid_o == $past(wdata_valid_o);
  endproperty
  a_mask : assert property (p_mask) else $error("masked beat stored");

  property p_strobe;
    rd_valid_i |=> dqs_t_o != $past(dqs_t_o) && dqs_c_o == !dqs_t_o && !dq_oe_n_o;
  endproperty
  a_strobe : assert property (p_strobe) else $error("strobe not aligned with data");

  property p_odt_gate;
    !rtt_nom_on && !rtt_wr_on |=> !odt_on_o;
  endproperty
  a_odt_gate : assert property (p_odt_gate) else $error("termination despite disable");
endmodule // ddrcp_core
`default_nettype wire

// >>> sim/ddrcp_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
// controller model driving command, address, termination and data pins
module ddrcp_ctrl_model
  import ddrcp_pkg::*;
(
  input  wire logic        core_clk_i,
  output var logic         cke_o,
  output var logic         cs_n_o,
  output var logic         ras_n_o,
  output var logic         cas_n_o,
  output var logic         we_n_o,
  output var logic [2:0]   ba_o,
  output var logic [14:0]  addr_o,
  output var logic         odt_o,
  output var logic         wr_beat_o,
  output var logic [15:0]  dq_o,
  output var logic [1:0]   dm_o,
  output var logic         rd_valid_o,
  output var logic [15:0]  rd_data_o
);
  // park the pins: no-operation code, clock enable high
  task automatic park();
    cke_o <= 1'b1;
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= CMD_NOP;
    ba_o <= 3'h0;
    addr_o <= 15'h0000;
    odt_o <= 1'b0;
    wr_beat_o <= 1'b0;
    dq_o <= 16'h0000;
    dm_o <= 2'b00;
    rd_valid_o <= 1'b0;
    rd_data_o <= 16'h0000;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // one command edge, then no-operation with address lines inverted
  task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [14:0] a,
                     input logic ck);
    @(posedge core_clk_i);
    cke_o <= ck;
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= c;
    ba_o <= b;
    addr_o <= a;
    @(posedge core_clk_i);
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= CMD_NOP;
    ba_o <= ~b;
    addr_o <= ~a;
  endtask
  // refresh followed by the full recovery gap
  task automatic ref_spaced();
    cmd(CMD_REF, 3'h0, 15'h0000, 1'b1);
    repeat (TRFC_CYC) @(posedge core_clk_i);
  endtask
  // hot-range refresh: next refresh follows at the halved interval
  task automatic ref_hot();
    cmd(CMD_REF, 3'h0, 15'h0000, 1'b1);
    repeat (TREFI_HOT_CYC - 2) @(posedge core_clk_i);
  endtask
  // write beat; the last one releases the data lines with inverted data
  task automatic beat(input logic [15:0] d, input logic [1:0] m, input logic last);
    @(posedge core_clk_i);
    wr_beat_o <= 1'b1;
    dq_o <= d;
    dm_o <= m;
    if (last) begin
      @(posedge core_clk_i);
      wr_beat_o <= 1'b0;
      dq_o <= ~d;
      dm_o <= ~m;
    end
  endtask
  // read beat from the array side
  task automatic rbeat(input logic [15:0] d);
    @(posedge core_clk_i);
    rd_valid_o <= 1'b1;
    rd_data_o <= d;
    @(posedge core_clk_i);
    rd_valid_o <= 1'b0;
    rd_data_o <= ~d;
  endtask
  task automatic set_cke(input logic v);
    @(posedge core_clk_i);
    cke_o <= v;
  endtask
  task automatic set_odt(input logic v);
    @(posedge core_clk_i);
    odt_o <= v;
  endtask
endmodule // ddrcp_ctrl_model
`default_nettype wire

// >>> sim/ddrcp_core_tb.sv
`timescale 1ns/10ps
`default_nettype none
module ddrcp_core_tb
  import ddrcp_pkg::*;
;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wdata_ready_i = 1'b0;
  logic cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, odt_i, wr_beat_i, rd_valid_i;
  logic wbeat_ready_o, wdata_valid_o, dq_oe_n_o, dqs_t_o, dqs_c_o, dqs_oe_n_o;
  logic cmd_act_o, cmd_rd_o, cmd_wr_o, cmd_pre_o, cmd_ref_o, cmd_mrs_o;
  logic cmd_ap_o, cmd_pre_all_o, cmd_full_burst_o, odt_on_o, tdqs_en_o, trfc_err_o;
  logic [2:0]  ba_i, cmd_bank_o;
  logic [14:0] addr_i, cmd_addr_o;
  logic [15:0] dq_i, wdata_o, rd_data_i, dq_o;
  logic [1:0]  dm_i;
  logic [7:0]  bank_open_o;
  logic [3:0]  pwr_state_o;
  int          error_cnt = 0;
  int          n_tests = 0;

  // 25 MHz clock
  always #20 core_clk_i = ~core_clk_i;

  ddrcp_core uut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .cke_i(cke_i), .cs_n_i(cs_n_i),
    .ras_n_i(ras_n_i), .cas_n_i(cas_n_i), .we_n_i(we_n_i), .ba_i(ba_i), .addr_i(addr_i),
    .odt_i(odt_i), .wr_beat_i(wr_beat_i), .dq_i(dq_i), .dm_i(dm_i),
    .wbeat_ready_o(wbeat_ready_o), .wdata_valid_o(wdata_valid_o), .wdata_o(wdata_o),
    .wdata_ready_i(wdata_ready_i), .rd_valid_i(rd_valid_i), .rd_data_i(rd_data_i),
    .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .dqs_t_o(dqs_t_o), .dqs_c_o(dqs_c_o),
    .dqs_oe_n_o(dqs_oe_n_o), .cmd_act_o(cmd_act_o), .cmd_rd_o(cmd_rd_o),
    .cmd_wr_o(cmd_wr_o), .cmd_pre_o(cmd_pre_o), .cmd_ref_o(cmd_ref_o),
    .cmd_mrs_o(cmd_mrs_o), .cmd_bank_o(cmd_bank_o), .cmd_addr_o(cmd_addr_o),
    .cmd_ap_o(cmd_ap_o), .cmd_pre_all_o(cmd_pre_all_o), .cmd_full_burst_o(cmd_full_burst_o),
    .bank_open_o(bank_open_o), .pwr_state_o(pwr_state_o), .odt_on_o(odt_on_o),
    .tdqs_en_o(tdqs_en_o), .trfc_err_o(trfc_err_o)
  );

  ddrcp_ctrl_model ctl (
    .core_clk_i(core_clk_i), .cke_o(cke_i), .cs_n_o(cs_n_i), .ras_n_o(ras_n_i),
    .cas_n_o(cas_n_i), .we_n_o(we_n_i), .ba_o(ba_i), .addr_o(addr_i), .odt_o(odt_i),
    .wr_beat_o(wr_beat_i), .dq_o(dq_i), .dm_o(dm_i), .rd_valid_o(rd_valid_i),
    .rd_data_o(rd_data_i)
  );
  //////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // wait edges, then let the updates settle
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  // check the head word, then pop it with a one-cycle ready
  task automatic pop(input logic [15:0] exp);
    chk(wdata_valid_o, 1'b1);
    chk(wdata_o, exp);
    @(posedge core_clk_i);
    wdata_ready_i <= 1'b1;
    @(posedge core_clk_i);
    wdata_ready_i <= 1'b0;
    #1;
  endtask
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    ctl.park();
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    #1;
    chk({pwr_state_o, bank_open_o}, {4'h1, 8'h00});
    chk({cmd_full_burst_o, wbeat_ready_o, dq_oe_n_o}, 3'b111);
    chk({dqs_oe_n_o, dqs_t_o, dqs_c_o, wdata_valid_o, trfc_err_o}, 5'b10100);
    // activate, then the same code with select high
    ctl.cmd(CMD_ACT, 3'h2, 15'h1234, 1'b1);
    #1;
    chk({cmd_act_o, cmd_bank_o, cmd_addr_o}, {1'b1, 3'h2, 15'h1234});
    chk(bank_open_o, 8'h04);
    ctl.cmd({1'b1, CMD_ACT[2:0]}, 3'h3, 15'h0001, 1'b1);
    #1;
    chk({cmd_act_o, bank_open_o}, {1'b0, 8'h04});
    // read with auto-precharge and chop, write without either
    ctl.cmd(CMD_RD, 3'h2, 15'h07ff, 1'b1);
    #1;
    chk({cmd_rd_o, cmd_addr_o}, {1'b1, 15'h03ff});
    chk({cmd_ap_o, bank_open_o}, {1'b1, 8'h00});
    chk(cmd_full_burst_o, 1'b0);
    ctl.cmd(CMD_WR, 3'h2, 15'h1005, 1'b1);
    #1;
    chk({cmd_wr_o, cmd_ap_o, cmd_addr_o}, {2'b10, 15'h0005});
    chk(cmd_full_burst_o, 1'b1);
    // single bank and all bank precharge
    ctl.cmd(CMD_ACT, 3'h1, 15'h0010, 1'b1);
    ctl.cmd(CMD_ACT, 3'h3, 15'h0020, 1'b1);
    ctl.cmd(CMD_PRE, 3'h1, 15'h0000, 1'b1);
    #1;
    chk({cmd_pre_o, cmd_pre_all_o, bank_open_o}, {2'b10, 8'h08});
    ctl.cmd(CMD_PRE, 3'h0, 15'h0400, 1'b1);
    #1;
    chk({cmd_pre_all_o, bank_open_o}, {1'b1, 8'h00});
    // mode registers, termination and strobe pair
    ctl.cmd(CMD_MRS, MR_SEL_1, 15'h0804, 1'b1);
    #1;
    chk({cmd_mrs_o, cmd_bank_o, cmd_addr_o}, {1'b1, 3'h1, 15'h0804});
    ctl.set_odt(1'b1);
    tick(2);
    chk({odt_on_o, tdqs_en_o}, 2'b11);
    ctl.cmd(CMD_MRS, MR_SEL_1, 15'h0000, 1'b1);
    tick(2);
    chk({odt_on_o, tdqs_en_o}, 2'b00);
    ctl.cmd(CMD_MRS, MR_SEL_2, 15'h0280, 1'b1);
    tick(2);
    chk(odt_on_o, 1'b1);
    ctl.set_odt(1'b0);
    tick(2);
    chk(odt_on_o, 1'b0);
    // refresh recovery kept, then broken
    ctl.ref_hot();
    ctl.ref_spaced();
    ctl.cmd(CMD_ACT, 3'h0, 15'h0000, 1'b1);
    #1;
    chk(trfc_err_o, 1'b0);
    ctl.cmd(CMD_REF, 3'h0, 15'h0000, 1'b1);
    #1;
    chk(cmd_ref_o, 1'b1);
    ctl.cmd(CMD_ACT, 3'h0, 15'h0000, 1'b1);
    #1;
    chk(trfc_err_o, 1'b1);
    ctl.cmd(CMD_PRE, 3'h0, 15'h0400, 1'b1);
    // precharge and active power-down
    ctl.set_cke(1'b0);
    tick(1);
    chk(pwr_state_o, 4'h2);
    ctl.set_cke(1'b1);
    tick(1);
    chk(pwr_state_o, 4'h1);
    ctl.cmd(CMD_ACT, 3'h5, 15'h0003, 1'b1);
    ctl.set_cke(1'b0);
    tick(1);
    chk(pwr_state_o, 4'h4);
    ctl.set_cke(1'b1);
    tick(1);
    chk(pwr_state_o, 4'h1);
    ctl.cmd(CMD_PRE, 3'h0, 15'h0400, 1'b1);
    // self-refresh: inputs ignored, slow exit
    ctl.cmd(CMD_REF, 3'h0, 15'h0000, 1'b0);
    #1;
    chk(pwr_state_o, 4'h8);
    ctl.cmd(CMD_ACT, 3'h6, 15'h0001, 1'b0);
    ctl.set_odt(1'b1);
    tick(2);
    chk({cmd_act_o, bank_open_o, odt_on_o}, {1'b0, 8'h00, 1'b0});
    ctl.set_cke(1'b1);
    tick(2);
    chk(pwr_state_o, 4'h8);
    tick(1);
    chk(pwr_state_o, 4'h8);
    tick(1);
    chk(pwr_state_o, 4'h1);
    ctl.set_odt(1'b0);
    // write beats: masking, full buffer with stalled sink, drain
    ctl.beat(16'ha5a5, 2'b00, 1'b0);
    ctl.beat(16'h1234, 2'b01, 1'b1);
    #1;
    chk({wdata_valid_o, wbeat_ready_o}, 2'b10);
    ctl.beat(16'hffff, 2'b00, 1'b1);
    #1;
    pop(16'ha5a5);
    pop(16'h1200);
    chk(wdata_valid_o, 1'b0);
    ctl.beat(16'h5555, 2'b11, 1'b1);
    tick(1);
    chk(wdata_valid_o, 1'b0);
    // read beat with complementary strobe
    ctl.rbeat(16'hc3c3);
    #1;
    chk({dq_o, dq_oe_n_o, dqs_oe_n_o}, {16'hc3c3, 2'b00});
    chk({dqs_t_o, dqs_c_o}, 2'b10);
    close_out();
  end
endmodule // ddrcp_core_tb
`default_nettype wire
